// ===== pkg/bmcr_pkg.sv
// package of command codes, field layouts, reset values and tables
// ****************************************************************
// Operation
// - pairing bit 0 interleaves four phases singly, 1 pairs 1/3 and 2/4.
// - mode bit 5 is unused, writes change nothing, reads mean nothing.
// - shed enable bit 0 turns dynamic phase shedding off, 1 turns it on.
// - load-line select 0 picks a non-zero load line, 1 a zero load line.
// - the 3-bit slew code picks one of eight rates, 0.34 to 2.74 mV/us.
// - ramp 000-101 gives 20-120 mVpp by 20 mV, 111 gives 200, 110 undefined.
// - a host ramp write overrides the current-limit/ramp strap default.
// - shed thresholds are percent of a full load of four overcurrent limits.
// - low bit 0 bars two to one phase, 1 drops to one phase below 10% load.
// - four-to-two threshold codes 000-011 give 15, 20, 25, 30%, others 35%.
// - two-bit lockout code picks 4.5, 7.25, 9.0 or 10.3 V and resets to 01.
// - max phase count set on the fly, 000 one to 101 six, never stored.
// - too many phases keeps the count, sets status bit 3, raises the alert.
// - uv fault level is set point less load-line drop less a 50-400 mV margin.
// - a 16-bit read-only id word reads back, writes to it have no effect.
// - mode register at DDh defaults from its pin strap, host writes win.
// ****************************************************************
package bmcr_pkg;

  // ****************************************************************
  // command codes
  // ****************************************************************
  localparam logic [7:0] CMD_SLEW_MODE = 8'hDD;
  localparam logic [7:0] CMD_RAMP      = 8'hDE;
  localparam logic [7:0] CMD_SHED      = 8'hDF;
  localparam logic [7:0] CMD_UVLO      = 8'hE0;
  localparam logic [7:0] CMD_PHASES    = 8'hE4;
  localparam logic [7:0] CMD_UVMARGIN  = 8'hE6;
  localparam logic [7:0] CMD_PART_ID   = 8'hFC;

  // ****************************************************************
  // reset values, field positions and masks
  // ****************************************************************
  localparam logic [7:0] RST_MODE      = 8'h00;
  localparam logic [7:0] RST_RAMP      = 8'h06;
  localparam logic [7:0] RST_SHED      = 8'h01;
  localparam logic [7:0] RST_UVLO      = 8'h01;
  localparam logic [7:0] RST_UVMARGIN  = 8'h03;
  localparam logic [7:0] MASK_MODE     = 8'hDF;
  localparam logic [7:0] MASK_3BIT     = 8'h07;
  localparam logic [7:0] MASK_SHED     = 8'h0F;
  localparam logic [7:0] MASK_UVLO     = 8'h03;
  localparam int         MODE_VID_BIT  = 7;
  localparam int         MODE_PAIR_BIT = 6;
  localparam int         MODE_SHED_BIT = 4;
  localparam int         MODE_ZLL_BIT  = 3;
  localparam int         SHED_LOW_BIT  = 3;
  localparam int         STAT_PH_BIT   = 3;
  localparam logic [2:0] STRAP_SETTLE_CYC = 3'h6;
  localparam logic [7:0] SLOTS_SINGLE  = 8'hE4;
  localparam logic [7:0] SLOTS_PAIRED  = 8'h44;

  // ****************************************************************
  // decode tables, entry 0 in the low bits
  // ****************************************************************
  localparam logic [7:0][11:0] SLEW_UV_PER_US = {12'hAB4, 12'h94C,
    12'h7F8, 12'h6A4, 12'h550, 12'h3FC, 12'h2A8, 12'h154};
  localparam logic [7:0][7:0] RAMP_MVPP_TAB = {8'hC8, 8'h00, 8'h78,
    8'h64, 8'h50, 8'h3C, 8'h28, 8'h14};
  localparam logic [3:0][13:0] UVLO_MV_TAB = {14'h283C, 14'h2328,
    14'h1C52, 14'h1194};
  localparam logic [7:0][8:0] UVM_MV_TAB = {9'h190, 9'h145, 9'h12C,
    9'h0FA, 9'h0C8, 9'h096, 9'h064, 9'h032};
  localparam logic [4:0][6:0] SHED_HI_PCT = {7'h23, 7'h1E, 7'h19,
    7'h14, 7'h0F};
  localparam logic [6:0] SHED_LO_PCT    = 7'h0A;
  localparam logic [2:0] FULL_LOAD_MULT = 3'h4;
  localparam logic [6:0] PCT_FULL       = 7'h64;

  // host command carried as one bundle
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  code;
    logic [15:0] wdata;
  } bmcr_cmd_type;

endpackage

// ===== rtl/bmcr_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module bmcr_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,   // system clock
  input  wire logic             rst,   // async reset, high
  input  wire logic [WIDTH-1:0] pin,   // raw pin level
  output logic      [WIDTH-1:0] level  // filtered level
);
  import bmcr_pkg::*;

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // ****************************************************************
  // per-bit chain, a change counts once stages two and three agree
  // ****************************************************************
  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        s1_q[i]  <= 1'b0;
        s2_q[i]  <= 1'b0;
        s3_q[i]  <= 1'b0;
        level[i] <= 1'b0;
      end else begin
        s1_q[i] <= pin[i];
        s2_q[i] <= s1_q[i];   // stage one feeds only this flop
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) begin
          level[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

// ===== rtl/bmcr_shed.sv
// dynamic phase shedding evaluator
`timescale 1ns/1ps
module bmcr_shed (
  input  wire logic       clk,       // system clock
  input  wire logic       rst,       // async reset, high
  input  wire logic       enable,    // shedding on
  input  wire logic       low_en,    // two to one allowed
  input  wire logic [2:0] high_code, // four to two threshold code
  input  wire logic [9:0] load,      // output current, amps
  input  wire logic [7:0] oc_limit,  // overcurrent limit, amps
  input  wire logic [2:0] max_cnt,   // allowed phases, 1..6
  output logic      [2:0] active     // phases in use
);
  import bmcr_pkg::*;

  logic [17:0] load_pct;
  logic [17:0] full_load;
  logic [6:0]  hi_pct;
  logic        below_lo;
  logic        below_hi;
  logic [2:0]  dual_cnt;

  // full load is four limits, so compare load*100 with pct*4*limit
  always_comb begin
    load_pct  = 18'(load) * 18'(PCT_FULL);
    full_load = 18'(oc_limit) * 18'(FULL_LOAD_MULT);
    hi_pct    = (high_code > 3'h3) ? SHED_HI_PCT[4]
                                   : SHED_HI_PCT[high_code];
    below_lo  = load_pct < 18'(full_load * 18'(SHED_LO_PCT));
    below_hi  = load_pct < 18'(full_load * 18'(hi_pct));
    dual_cnt  = (max_cnt < 3'h2) ? max_cnt : 3'h2;
  end

  // registered choice keeps the output glitch free
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active <= 3'h1;
    end else if (!enable) begin
      active <= max_cnt;
    end else if (low_en && below_lo) begin
      active <= 3'h1;
    end else if (below_hi) begin
      active <= dual_cnt;
    end else begin
      active <= max_cnt;
    end
  end
endmodule

// ===== rtl/bmcr_top.sv
// buck mode configuration register bank
`timescale 1ns/1ps
module bmcr_top #(
  parameter logic [2:0]  HW_PHASES = 3'h4,     // phases fitted
  parameter logic [15:0] PART_ID   = 16'h5A3C  // value is arbitrary
) (
  input  wire logic                  CLK,                  // 50 MHz
  input  wire logic                  RST,                  // async, high
  input  wire bmcr_pkg::bmcr_cmd_type CMD,                 // host command
  input  wire logic [7:0]            SLEW_MODE_STRAP,      // strap pins
  input  wire logic [2:0]            CURRENT_LIMIT_RAMP_STRAP, // strap
  input  wire logic [9:0]            LOAD_CURRENT,         // amps
  input  wire logic [7:0]            OVERCURRENT_LIMIT_LEVEL, // amps
  input  wire logic [11:0]           VOUT_CMD_MV,          // set point
  input  wire logic [11:0]           LOADLINE_DROP_MV,     // ll * iout
  input  wire logic                  STATUS_CLEAR,         // clear pulse
  output logic                       CMD_ACK,              // mapped
  output logic                       CMD_NAK,              // unmapped
  output logic                       RD_VALID,             // read data
  output logic [15:0]                RDATA,                // read word
  output logic                       VID_TABLE_SELECT,     // table
  output logic                       INTERLEAVE_PAIRING,   // paired
  output logic [7:0]                 PHASE_SLOTS,          // 2b/phase
  output logic                       PHASE_SHED_ENABLE,    // shed on
  output logic                       ZERO_LOADLINE_SELECT, // zero ll
  output logic [11:0]                SLEW_RATE_UV_PER_US,  // slew
  output logic [7:0]                 RAMP_MVPP,            // ramp
  output logic [13:0]                INPUT_LOCKOUT_MV,     // uvlo
  output logic [2:0]                 ACTIVE_PHASES,        // in use
  output logic [11:0]                UVF_THRESHOLD_MV,     // uv fault
  output logic [7:0]                 VENDOR_STATUS_WORD,   // status
  output logic                       HOST_ALERT_OUTPUT_N   // alert, low
);
  import bmcr_pkg::*;

  logic [7:0]  mode_q;
  logic [7:0]  ramp_q;
  logic [7:0]  shed_q;
  logic [7:0]  uvlo_q;
  logic [7:0]  phase_q;
  logic [7:0]  uvm_q;
  logic        mode_written_q;
  logic        ramp_written_q;
  logic [2:0]  settle_q;
  logic        strap_take;
  logic [10:0] strap_level;
  logic        wr_mode;
  logic        wr_ramp;
  logic        wr_phase;
  logic        phase_over;
  logic        mapped;
  logic [15:0] rd_mux;
  logic [2:0]  phase_cnt;
  logic [12:0] uv_sub;
  logic [12:0] uv_top;
  logic [2:0]  slew_code;
  logic [2:0]  ramp_code;

  // ****************************************************************
  // strap pins come from outside, filtered before capture
  // ****************************************************************
  bmcr_sync #(
    .WIDTH (11)
  ) u_strap_sync (
    .clk   (CLK),
    .rst   (RST),
    .pin   ({CURRENT_LIMIT_RAMP_STRAP, SLEW_MODE_STRAP}),
    .level (strap_level)
  );

  // strap capture waits for the filter to fill after release
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      settle_q <= 3'h0;
    end else if (settle_q != STRAP_SETTLE_CYC) begin
      settle_q <= settle_q + 3'h1;
    end
  end

  assign strap_take = (settle_q == (STRAP_SETTLE_CYC - 3'h1));

  // ****************************************************************
  // command decode
  // ****************************************************************
  always_comb begin
    unique case (CMD.code)
      CMD_SLEW_MODE, CMD_RAMP, CMD_SHED, CMD_UVLO,
      CMD_PHASES, CMD_UVMARGIN, CMD_PART_ID: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign wr_mode    = CMD.wr && (CMD.code == CMD_SLEW_MODE);
  assign wr_ramp    = CMD.wr && (CMD.code == CMD_RAMP);
  assign wr_phase   = CMD.wr && (CMD.code == CMD_PHASES);
  assign phase_over = CMD.wdata[2:0] > (HW_PHASES - 3'h1);

  // ****************************************************************
  // mode and slew register, host write beats the strap
  // ****************************************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mode_q         <= RST_MODE;
      mode_written_q <= 1'b0;
    end else if (wr_mode) begin
      mode_q         <= CMD.wdata[7:0] & MASK_MODE;
      mode_written_q <= 1'b1;
    end else if (strap_take && !mode_written_q) begin
      mode_q         <= strap_level[7:0] & MASK_MODE;
    end
  end

  // ramp register, a write made before the strap settles still wins
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ramp_q         <= RST_RAMP;
      ramp_written_q <= 1'b0;
    end else if (wr_ramp) begin
      ramp_q         <= CMD.wdata[7:0] & MASK_3BIT;
      ramp_written_q <= 1'b1;
    end else if (strap_take && !ramp_written_q) begin
      ramp_q         <= {5'h00, strap_level[10:8]};
    end
  end

  // plain settings registers, reserved bits held at zero
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      shed_q <= RST_SHED;
      uvlo_q <= RST_UVLO;
      uvm_q  <= RST_UVMARGIN;
    end else if (CMD.wr) begin
      if (CMD.code == CMD_SHED) begin
        shed_q <= CMD.wdata[7:0] & MASK_SHED;
      end
      if (CMD.code == CMD_UVLO) begin
        uvlo_q <= CMD.wdata[7:0] & MASK_UVLO;
      end
      if (CMD.code == CMD_UVMARGIN) begin
        uvm_q <= CMD.wdata[7:0] & MASK_3BIT;
      end
    end
  end

  // volatile phase limit, starts at what the hardware provides
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      phase_q <= {5'h00, HW_PHASES - 3'h1};
    end else if (wr_phase && !phase_over) begin
      phase_q <= CMD.wdata[7:0] & MASK_3BIT;
    end
  end

  // sticky vendor status, a new overflow beats a clear
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      VENDOR_STATUS_WORD <= 8'h00;
    end else if (wr_phase && phase_over) begin
      VENDOR_STATUS_WORD[STAT_PH_BIT] <= 1'b1;
    end else if (STATUS_CLEAR) begin
      VENDOR_STATUS_WORD <= 8'h00;
    end
  end

  // alert follows status one cycle later
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      HOST_ALERT_OUTPUT_N <= 1'b1;
    end else begin
      HOST_ALERT_OUTPUT_N <= ~(|VENDOR_STATUS_WORD);
    end
  end

  // ****************************************************************
  // read path and command answer
  // ****************************************************************
  always_comb begin
    rd_mux = 16'h0000;
    unique case (CMD.code)
      CMD_SLEW_MODE: rd_mux = {8'h00, mode_q};
      CMD_RAMP:      rd_mux = {8'h00, ramp_q};
      CMD_SHED:      rd_mux = {8'h00, shed_q};
      CMD_UVLO:      rd_mux = {8'h00, uvlo_q};
      CMD_PHASES:    rd_mux = {8'h00, phase_q};
      CMD_UVMARGIN:  rd_mux = {8'h00, uvm_q};
      CMD_PART_ID:   rd_mux = PART_ID;
      default:       rd_mux = 16'h0000;
    endcase
  end

  // writes to the id are acknowledged and dropped
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      CMD_ACK  <= 1'b0;
      CMD_NAK  <= 1'b0;
      RD_VALID <= 1'b0;
      RDATA    <= 16'h0000;
    end else begin
      CMD_ACK  <= (CMD.wr || CMD.rd) && mapped;
      CMD_NAK  <= (CMD.wr || CMD.rd) && !mapped;
      RD_VALID <= CMD.rd;
      if (CMD.rd) begin
        RDATA <= rd_mux;
      end
    end
  end

  // ****************************************************************
  // decoded settings toward the power stage
  // ****************************************************************
  assign slew_code = mode_q[2:0];
  assign ramp_code = ramp_q[2:0];
  assign phase_cnt = phase_q[2:0] + 3'h1;
  assign uv_sub    = (mode_q[MODE_ZLL_BIT] ? 13'h0000
                      : 13'(LOADLINE_DROP_MV))
                     + 13'(UVM_MV_TAB[uvm_q[2:0]]);
  assign uv_top    = 13'(VOUT_CMD_MV);

  // code 110 of the ramp is undefined and reads out as zero
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      VID_TABLE_SELECT     <= 1'b0;
      INTERLEAVE_PAIRING   <= 1'b0;
      PHASE_SLOTS          <= SLOTS_SINGLE;
      PHASE_SHED_ENABLE    <= 1'b0;
      ZERO_LOADLINE_SELECT <= 1'b0;
      SLEW_RATE_UV_PER_US  <= SLEW_UV_PER_US[0];
      RAMP_MVPP            <= RAMP_MVPP_TAB[0];
      INPUT_LOCKOUT_MV     <= UVLO_MV_TAB[1];
      UVF_THRESHOLD_MV     <= 12'h000;
    end else begin
      VID_TABLE_SELECT     <= mode_q[MODE_VID_BIT];
      INTERLEAVE_PAIRING   <= mode_q[MODE_PAIR_BIT];
      PHASE_SLOTS          <= mode_q[MODE_PAIR_BIT] ? SLOTS_PAIRED
                                                    : SLOTS_SINGLE;
      PHASE_SHED_ENABLE    <= mode_q[MODE_SHED_BIT];
      ZERO_LOADLINE_SELECT <= mode_q[MODE_ZLL_BIT];
      SLEW_RATE_UV_PER_US  <= SLEW_UV_PER_US[slew_code];
      RAMP_MVPP            <= RAMP_MVPP_TAB[ramp_code];
      INPUT_LOCKOUT_MV     <= UVLO_MV_TAB[uvlo_q[1:0]];
      // clamp at zero so a large drop cannot wrap
      UVF_THRESHOLD_MV     <= (uv_top > uv_sub) ? 12'(uv_top - uv_sub)
                                                : 12'h000;
    end
  end

  // ****************************************************************
  // phase shedding
  // ****************************************************************
  bmcr_shed u_shed (
    .clk       (CLK),
    .rst       (RST),
    .enable    (mode_q[MODE_SHED_BIT]),
    .low_en    (shed_q[SHED_LOW_BIT]),
    .high_code (shed_q[2:0]),
    .load      (LOAD_CURRENT),
    .oc_limit  (OVERCURRENT_LIMIT_LEVEL),
    .max_cnt   (phase_cnt),
    .active    (ACTIVE_PHASES)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_pairing_slots: assert property (
    ##1 PHASE_SLOTS == ($past(mode_q[MODE_PAIR_BIT]) ? SLOTS_PAIRED
                                                     : SLOTS_SINGLE))
    else $error("phase slots do not follow pairing bit");

  a_unused_bit: assert property (
    CMD.rd && CMD.code == CMD_SLEW_MODE |=> RD_VALID && !RDATA[5])
    else $error("unused mode bit read back nonzero");

  a_shed_off: assert property (
    !mode_q[MODE_SHED_BIT] && $stable(phase_cnt) |=>
      ACTIVE_PHASES == $past(phase_cnt))
    else $error("phases shed while shedding disabled");

  a_slew_map: assert property (
    ##1 SLEW_RATE_UV_PER_US == SLEW_UV_PER_US[$past(slew_code)])
    else $error("slew rate does not match code");

  a_ramp_write: assert property (
    wr_ramp |=> ramp_q == ($past(CMD.wdata[7:0]) & MASK_3BIT) ##1
      RAMP_MVPP == RAMP_MVPP_TAB[$past(CMD.wdata[2:0], 2)])
    else $error("ramp write lost to strap");

  a_mode_write: assert property (
    wr_mode |=> mode_q == ($past(CMD.wdata[7:0]) & MASK_MODE))
    else $error("mode write not taken");

  a_lockout_reset: assert property (
    $fell(RST) |-> uvlo_q == RST_UVLO)
    else $error("lockout code not at reset value");

  a_phase_over: assert property (
    wr_phase && phase_over |=> $stable(phase_q) &&
      VENDOR_STATUS_WORD[STAT_PH_BIT] ##1 !HOST_ALERT_OUTPUT_N)
    else $error("phase overflow not flagged");

  a_phase_take: assert property (
    wr_phase && !phase_over |=> phase_q[2:0] == $past(CMD.wdata[2:0]))
    else $error("legal phase count not taken");

  a_id_read: assert property (
    CMD.rd && CMD.code == CMD_PART_ID |=> RD_VALID && RDATA == PART_ID)
    else $error("identification word wrong");

  a_nak_unmapped: assert property (
    (CMD.wr || CMD.rd) && !mapped |=> CMD_NAK && !CMD_ACK)
    else $error("unmapped code not refused");

  a_lockout_write: assert property (
    CMD.wr && CMD.code == CMD_UVLO |=>
      uvlo_q == ($past(CMD.wdata[7:0]) & MASK_UVLO))
    else $error("lockout code not taken");

  a_lockout_map: assert property (
    ##1 INPUT_LOCKOUT_MV == UVLO_MV_TAB[$past(uvlo_q[1:0])])
    else $error("lockout level does not match code");

  a_ramp_top: assert property (
    ramp_q[2:0] == 3'h7 |=> RAMP_MVPP == 8'hC8)
    else $error("top ramp code not 200 mV");

  a_status_clear: assert property (
    STATUS_CLEAR && !(wr_phase && phase_over) |=> VENDOR_STATUS_WORD == 8'h00)
    else $error("status not cleared");

  a_alert_follow: assert property (
    ##1 HOST_ALERT_OUTPUT_N == !(|$past(VENDOR_STATUS_WORD)))
    else $error("alert does not follow status");

  a_low_shed_off: assert property (
    mode_q[MODE_SHED_BIT] && !shed_q[SHED_LOW_BIT] && phase_cnt > 3'h1
      |=> ACTIVE_PHASES != 3'h1)
    else $error("dropped to one phase while forbidden");

  // covers: the main scenarios are reached at least once
  c_pair_on: cover property (wr_mode && CMD.wdata[MODE_PAIR_BIT]);
  c_ramp_write: cover property (wr_ramp && !ramp_written_q);
  c_overflow: cover property (wr_phase && phase_over);
  c_strap: cover property (strap_take && !mode_written_q);
  c_one_phase: cover property (ACTIVE_PHASES == 3'h1);
endmodule

// ===== bench/bmcr_host.sv
// host model that issues commands and notes the read data it expects
`timescale 1ns/1ps
module bmcr_host (
  input  wire logic              clk, // system clock
  output bmcr_pkg::bmcr_cmd_type cmd  // command bundle to the bank
);
  import bmcr_pkg::*;
  logic [16:0] exp_q[$]; // {nak, data} of each read, oldest first
  // idle from time zero, so nothing is taken while reset is held
  initial cmd = '0;
  // a strobe stands one edge only; wr and rd never share a cycle
  task automatic send(input logic w, input logic [7:0] code,
                      input logic [15:0] data);
    @(posedge clk);
    cmd <= '{wr: w, rd: !w, code: code, wdata: data};
    @(posedge clk);
    cmd.wr <= 1'b0;
    cmd.rd <= 1'b0;
  endtask
  // the expectation is queued before the strobe, so it is never late
  task automatic read_reg(input logic [7:0] code, input logic nak,
                          input logic [15:0] exp);
    exp_q.push_back({nak, exp});
    send(1'b0, code, 16'h0000);
  endtask
endmodule

// ===== bench/bmcr_top_tb.sv
// self-checking bench for the mode configuration register bank
`timescale 1ns/1ps
module bmcr_top_tb;
  import bmcr_pkg::*;
  localparam logic [15:0] ID_VAL = 16'hC3A5; // value is arbitrary
  localparam int UVLO[4] = '{4500, 7250, 9000, 10300};
  localparam int MARG[8] = '{50, 100, 150, 200, 250, 300, 325, 400};
  localparam int SH_REG[6] = '{8, 8, 8, 4, 4, 3};
  localparam int SH_LD[6] = '{2, 5, 8, 2, 13, 13};
  localparam int SH_EX[6] = '{1, 2, 4, 2, 2, 4};
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         clr = 1'b0;
  logic [9:0]   load = 10'h000;
  logic [7:0]   m, r, slots, ramp, status;
  logic         ack, nak, rdv, vid, pair, shen, zll, alert_n;
  logic [15:0]  rdata;
  logic [16:0]  rd_exp;
  logic [11:0]  slew, uvf;
  logic [13:0]  lock;
  logic [2:0]   act;
  bmcr_cmd_type cmd;
  int           fail_count = 0;
  int           comparisons = 0;

  always #10 clk = ~clk;

  bmcr_host bmcr_host_i (.clk(clk), .cmd(cmd));
  // straps, limit and set point are tied: their paths are checked once
  bmcr_top #(.PART_ID(ID_VAL)) bmcr_top_i (
    .CLK(clk), .RST(rst), .CMD(cmd), .SLEW_MODE_STRAP(8'h2B),
    .CURRENT_LIMIT_RAMP_STRAP(3'h2), .LOAD_CURRENT(load),
    .OVERCURRENT_LIMIT_LEVEL(8'h0A), .VOUT_CMD_MV(12'h4B0),
    .LOADLINE_DROP_MV(12'h064), .STATUS_CLEAR(clr), .CMD_ACK(ack),
    .CMD_NAK(nak), .RD_VALID(rdv), .RDATA(rdata),
    .VID_TABLE_SELECT(vid), .INTERLEAVE_PAIRING(pair),
    .PHASE_SLOTS(slots), .PHASE_SHED_ENABLE(shen),
    .ZERO_LOADLINE_SELECT(zll), .SLEW_RATE_UV_PER_US(slew),
    .RAMP_MVPP(ramp), .INPUT_LOCKOUT_MV(lock), .ACTIVE_PHASES(act),
    .UVF_THRESHOLD_MV(uvf), .VENDOR_STATUS_WORD(status),
    .HOST_ALERT_OUTPUT_N(alert_n));

  // ****************************************************************
  // compare and closing tasks
  // ****************************************************************
  task automatic chk_out(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_read(input logic [16:0] exp, input logic [16:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value read expected %h seen %h", exp, got);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    bmcr_host_i.send(1'b1, code, data);
  endtask
  task automatic rd(input logic [7:0] c, input logic n, input logic [15:0] e);
    bmcr_host_i.read_reg(c, n, e);
  endtask
  // derived outputs lag the request edge, five edges covers all of them
  task automatic settle;
    repeat (5) @(posedge clk);
  endtask

  // read results: oldest note against each data-valid pulse
  always @(posedge clk) begin
    if (rdv === 1'b1) begin
      rd_exp = bmcr_host_i.exp_q.size() > 0 ?
               bmcr_host_i.exp_q.pop_front() : 17'h1FFFF;
      chk_read(rd_exp, {nak, rdata});
      chk_out("ack", 16'(!rd_exp[16]), 16'(ack));
    end
  end

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk);
    fail_count++;
    close_out();
  end

  initial begin
    void'($urandom(32));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (12) @(posedge clk);
    rd(CMD_SLEW_MODE, 1'b0, 16'h000B);
    rd(CMD_RAMP, 1'b0, 16'h0002);
    rd(CMD_SHED, 1'b0, 16'h0001);
    rd(CMD_UVLO, 1'b0, 16'h0001);
    rd(CMD_PHASES, 1'b0, 16'h0003);
    rd(CMD_UVMARGIN, 1'b0, 16'h0003);
    wr(CMD_PART_ID, 16'h0000);
    rd(CMD_PART_ID, 1'b0, ID_VAL);
    rd(8'hD0, 1'b1, 16'h0000);
    // every slew, ramp, lockout and margin code, random upper bits dropped except mode bits 7, 6, 4 and 3
    for (int i = 0; i < 8; i++) begin
      r = 8'($urandom());
      m = {r[7:3], 3'(i)};
      wr(CMD_SLEW_MODE, {8'h00, m});
      wr(CMD_RAMP, {8'h00, r[7:3], 3'(i)});
      wr(CMD_UVLO, {8'h00, r[7:2], 2'(i)});
      wr(CMD_UVMARGIN, {8'h00, r[7:3], 3'(i)});
      rd(CMD_SLEW_MODE, 1'b0, {8'h00, m & MASK_MODE});
      rd(CMD_RAMP, 1'b0, 16'(i));
      rd(CMD_UVLO, 1'b0, 16'(i % 4));
      settle();
      chk_out("slew", 16'(i == 7 ? 2740 : 340 * (i + 1)), 16'(slew));
      chk_out("ramp", 16'(i == 6 ? 0 : i == 7 ? 200 : 20 * (i + 1)),
              16'(ramp));
      chk_out("lockout", 16'(UVLO[i % 4]), 16'(lock));
      chk_out("uvf", 16'(1100 + (m[3] ? 100 : 0) - MARG[i]), 16'(uvf));
      chk_out("slots", m[6] ? 16'h0044 : 16'h00E4, 16'(slots));
      chk_out("mode", 16'({m[7], m[6], m[4], m[3]}),
              16'({vid, pair, shen, zll}));
    end
    wr(CMD_SLEW_MODE, 16'h0000);
    wr(CMD_PHASES, 16'h0001);
    rd(CMD_PHASES, 1'b0, 16'h0001);
    settle();
    chk_out("active", 16'h0002, 16'(act));
    // a count above the fitted phases is kept out and flagged
    wr(CMD_PHASES, 16'h0005);
    rd(CMD_PHASES, 1'b0, 16'h0001);
    settle();
    chk_out("status", 16'h0008, 16'(status));
    chk_out("alert", 16'h0000, 16'(alert_n));
    chk_out("active", 16'h0002, 16'(act));
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    settle();
    chk_out("alert", 16'h0001, 16'(alert_n));
    chk_out("status", 16'h0000, 16'(status));
    // full load is four times a 10 A limit, so 40 A
    wr(CMD_PHASES, 16'h0003);
    wr(CMD_SLEW_MODE, 16'h0010);
    for (int k = 0; k < 6; k++) begin
      load <= 10'(SH_LD[k]);
      wr(CMD_SHED, 16'(SH_REG[k]));
      settle();
      chk_out("active", 16'(SH_EX[k]), 16'(act));
    end
    wr(CMD_SLEW_MODE, 16'h0000);
    settle();
    chk_out("active", 16'h0004, 16'(act));
    close_out();
  end
endmodule
